// ==== src/scp_pkg.sv ====
// Notes on behaviour
// - Bit 0 write one resets port, registers.
// - Bit 7 mirrors the soft reset action.
// - Bit-order bits select LSB or MSB first.
// - Direction bits select address increment or decrement.
// - Datapath reset bit pulses, then self-clears.
// - Mode 00 normal, 10 standby keeps link.
// - Mode 11 stops clocks, resets datapath, link off.
// - Power mode writes go to each selected channel; datapath reset goes to both.
// - Both channels selected reads return channel A.
package scp_pkg;
   localparam logic [15:0] ADDR_CFG_A = 16'h0000;
   localparam logic [15:0] ADDR_CFG_B = 16'h0001;
   localparam logic [15:0] ADDR_PWR = 16'h0002;
   localparam logic [15:0] ADDR_CLASS = 16'h0003;
   localparam logic [15:0] ADDR_ID_LO = 16'h0004;
   localparam logic [15:0] ADDR_ID_HI = 16'h0005;
   localparam logic [15:0] ADDR_CHSEL = 16'h0008;
   localparam int BIT_SRST = 0;
   localparam int BIT_LSBF = 1;
   localparam int BIT_ASC = 2;
   localparam int BIT_ASC_M = 5;
   localparam int BIT_LSBF_M = 6;
   localparam int BIT_SRST_M = 7;
   localparam int BIT_DPRST = 1;
   localparam logic [1:0] CHSEL_RST = 2'h3;
   localparam logic [1:0] PM_NORMAL = 2'h0;
   localparam logic [1:0] PM_STANDBY = 2'h2;
   localparam logic [1:0] PM_DOWN = 2'h3;
   localparam logic [7:0] CLASS_CODE = 8'h5A; // Arbitrary value
   localparam logic [15:0] PART_ID = 16'h00A5; // Arbitrary value
   localparam int SRST_WAIT_MS = 5;
   typedef struct packed {
      logic dp_clk_en;
      logic dp_rst;
      logic link_en;
   } scp_chan_ctl_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } scp_req_t;
endpackage

// ==== src/scp_chan_pwr.sv ====
`timescale 1ns/10ps
module scp_chan_pwr (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic [1:0] mode_wdata_i,
   input wire logic dp_rst_pulse_i,
   output logic [1:0] mode_o,
   output scp_pkg::scp_chan_ctl_t ctl_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_o <= scp_pkg::PM_NORMAL;
      end else if (wr_i) begin
         mode_o <= mode_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_o <= '{dp_clk_en: 1'h1, dp_rst: 1'h1, link_en: 1'h1};
      end else begin
         ctl_o.dp_clk_en <= (mode_o == scp_pkg::PM_NORMAL);
         ctl_o.dp_rst <= dp_rst_pulse_i || (mode_o == scp_pkg::PM_DOWN);
         ctl_o.link_en <= (mode_o != scp_pkg::PM_DOWN);
      end
   end
endmodule // scp_chan_pwr

// ==== src/scp_regs.sv ====
`timescale 1ns/10ps
module scp_regs (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input scp_pkg::scp_req_t req_i,
   output logic [7:0] rdata_o,
   output logic lsb_first_o,
   output logic addr_ascend_o,
   output logic port_rst_o,
   output scp_pkg::scp_chan_ctl_t chan_a_o,
   output scp_pkg::scp_chan_ctl_t chan_b_o
);
   localparam int NUM_CHAN = 2;

   // Address match for one register
   function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] reg_addr);
      addr_hit = (addr == reg_addr);
   endfunction

   // Write strobe for one register
   function automatic logic wr_hit(input scp_pkg::scp_req_t req,
         input logic [15:0] reg_addr);
      wr_hit = req.wr && addr_hit(req.addr, reg_addr);
   endfunction

   // Either copy of a mirrored bit
   function automatic logic copy_or(input logic [7:0] data, input int primary,
         input int mirror);
      copy_or = data[primary] || data[mirror];
   endfunction

   // Read image of the first configuration register
   function automatic logic [7:0] cfg_a_image(input logic lsb, input logic asc);
      logic [7:0] img;
      img = 8'h00;
      img[scp_pkg::BIT_LSBF] = lsb;
      img[scp_pkg::BIT_LSBF_M] = lsb;
      img[scp_pkg::BIT_ASC] = asc;
      img[scp_pkg::BIT_ASC_M] = asc;
      cfg_a_image = img;
   endfunction

   // Channel A wins when both are selected
   function automatic logic [1:0] mode_pick(input logic [1:0] sel, input logic [1:0] m_a,
         input logic [1:0] m_b);
      if (sel[0]) begin
         mode_pick = m_a;
      end else begin
         mode_pick = m_b;
      end
   endfunction

   // Read data for one address
   function automatic logic [7:0] read_mux(input logic [15:0] addr, input logic lsb,
         input logic asc, input logic [1:0] sel, input logic [1:0] m_a,
         input logic [1:0] m_b);
      logic [7:0] data;
      data = 8'h00;
      case (addr)
         scp_pkg::ADDR_CFG_A: begin
            data = cfg_a_image(lsb, asc);
         end
         scp_pkg::ADDR_CFG_B: begin
            data = 8'h00;
         end
         scp_pkg::ADDR_PWR: begin
            data = {6'h00, mode_pick(sel, m_a, m_b)};
         end
         scp_pkg::ADDR_CLASS: begin
            data = scp_pkg::CLASS_CODE;
         end
         scp_pkg::ADDR_ID_LO: begin
            data = scp_pkg::PART_ID[7:0];
         end
         scp_pkg::ADDR_ID_HI: begin
            data = scp_pkg::PART_ID[15:8];
         end
         scp_pkg::ADDR_CHSEL: begin
            data = {6'h00, sel};
         end
         default: begin
            data = 8'h00;
         end
      endcase
      read_mux = data;
   endfunction

   logic wr_cfg_a;
   logic wr_cfg_b;
   logic wr_pwr;
   logic wr_chsel;
   logic srst_req;
   logic lsbf_req;
   logic asc_req;
   logic dprst_req;
   logic [1:0] mode_req;
   logic [1:0] chsel_req;
   logic soft_rst;
   logic rst_all;
   logic lsb_first;
   logic addr_ascend;
   logic dp_rst_pulse;
   logic [1:0] chan_sel;
   logic [1:0] chan_mode [NUM_CHAN];
   scp_pkg::scp_chan_ctl_t chan_ctl [NUM_CHAN];
   logic [7:0] next_rdata;

   assign wr_cfg_a = wr_hit(req_i, scp_pkg::ADDR_CFG_A);
   assign wr_cfg_b = wr_hit(req_i, scp_pkg::ADDR_CFG_B);
   assign wr_pwr = wr_hit(req_i, scp_pkg::ADDR_PWR);
   assign wr_chsel = wr_hit(req_i, scp_pkg::ADDR_CHSEL);
   assign srst_req = wr_cfg_a
                     && copy_or(req_i.wdata, scp_pkg::BIT_SRST, scp_pkg::BIT_SRST_M);
   assign lsbf_req = copy_or(req_i.wdata, scp_pkg::BIT_LSBF,
                             scp_pkg::BIT_LSBF_M);
   assign asc_req = copy_or(req_i.wdata, scp_pkg::BIT_ASC,
                            scp_pkg::BIT_ASC_M);
   assign dprst_req = wr_cfg_b && req_i.wdata[scp_pkg::BIT_DPRST];
   assign mode_req = req_i.wdata[1:0];
   assign chsel_req = req_i.wdata[1:0];
   assign rst_all = sys_rst_i || soft_rst;

   // One-cycle self-clearing soft reset
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         soft_rst <= 1'h0;
      end else begin
         soft_rst <= srst_req;
      end
   end

   // Stored bit-order select
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         lsb_first <= 1'h0;
      end else if (wr_cfg_a) begin
         lsb_first <= lsbf_req;
      end
   end

   // Stored address direction
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         addr_ascend <= 1'h0;
      end else if (wr_cfg_a) begin
         addr_ascend <= asc_req;
      end
   end

   // Datapath reset pulse
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         dp_rst_pulse <= 1'h0;
      end else begin
         dp_rst_pulse <= dprst_req;
      end
   end

   // Channel select, both set after reset
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         chan_sel <= scp_pkg::CHSEL_RST;
      end else if (wr_chsel) begin
         chan_sel <= chsel_req;
      end
   end

   // One power controller per channel
   generate
      for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
         scp_chan_pwr u_chan (
            .clk_i(clk_i),
            .rst_i(rst_all),
            .wr_i(wr_pwr && chan_sel[g]),
            .mode_wdata_i(mode_req),
            .dp_rst_pulse_i(dp_rst_pulse),
            .mode_o(chan_mode[g]),
            .ctl_o(chan_ctl[g])
         );
      end
   endgenerate

   assign chan_a_o = chan_ctl[0];
   assign chan_b_o = chan_ctl[1];

   // Read data holds until the next read
   always_comb begin
      next_rdata = rdata_o;
      if (req_i.rd) begin
         next_rdata = read_mux(req_i.addr, lsb_first, addr_ascend, chan_sel,
               chan_mode[0], chan_mode[1]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= next_rdata;
      end
   end

   // Bit-order and direction outputs follow the stored bits, port reset follows soft_rst
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         lsb_first_o <= 1'h0;
      end else begin
         lsb_first_o <= lsb_first && !rst_all;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         addr_ascend_o <= 1'h0;
      end else begin
         addr_ascend_o <= addr_ascend && !rst_all;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         port_rst_o <= 1'h1;
      end else begin
         port_rst_o <= soft_rst;
      end
   end
endmodule // scp_regs

// ==== testbench/scp_checker.sv ====
`timescale 1ns/10ps
module scp_checker (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input scp_pkg::scp_req_t req_i,
   input wire logic [7:0] rdata_o,
   input wire logic lsb_first_o,
   input wire logic addr_ascend_o,
   input wire logic port_rst_o,
   input scp_pkg::scp_chan_ctl_t chan_a_o,
   input scp_pkg::scp_chan_ctl_t chan_b_o
);
   wire wr = req_i.wr;
   wire rd = req_i.rd;
   wire [15:0] ad = req_i.addr;
   wire [7:0] wd = req_i.wdata;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_srst; wr && ad == 16'h0000 && wd[0] |-> ##2 port_rst_o; endproperty
   a_srst: assert property (p_srst) else $error("no port reset");
   property p_srst_m; wr && ad == 16'h0000 && wd[7] |-> ##2 port_rst_o; endproperty
   a_srst_m: assert property (p_srst_m) else $error("no mirror reset");
   property p_lsb; wr && ad == 16'h0000 && !wd[0] && !wd[7]
      |-> ##2 lsb_first_o == $past(wd[1] | wd[6], 2); endproperty
   a_lsb: assert property (p_lsb) else $error("bit order");
   property p_asc; wr && ad == 16'h0000 && !wd[0] && !wd[7]
      |-> ##2 addr_ascend_o == $past(wd[2] | wd[5], 2); endproperty
   a_asc: assert property (p_asc) else $error("address step");
   property p_dprst; wr && ad == 16'h0001 && wd[1]
      |-> ##2 chan_a_o.dp_rst && chan_b_o.dp_rst; endproperty
   a_dprst: assert property (p_dprst) else $error("datapath reset");
   property p_down; !chan_a_o.link_en |-> !chan_a_o.dp_clk_en && chan_a_o.dp_rst; endproperty
   a_down: assert property (p_down) else $error("power down");
   property p_class; rd && ad == 16'h0003 |=> rdata_o == scp_pkg::CLASS_CODE; endproperty
   a_class: assert property (p_class) else $error("class code");
   property p_mirror; rd && ad == 16'h0000
      |=> rdata_o[1] == rdata_o[6] && rdata_o[2] == rdata_o[5]; endproperty
   a_mirror: assert property (p_mirror) else $error("mirror copy");
   property p_prst_once; port_rst_o |=> !port_rst_o; endproperty
   a_prst_once: assert property (p_prst_once) else $error("port reset held");
   property p_down_b; !chan_b_o.link_en
      |-> !chan_b_o.dp_clk_en && chan_b_o.dp_rst; endproperty
   a_down_b: assert property (p_down_b) else $error("power down b");
   property p_run_a; chan_a_o.dp_clk_en |-> chan_a_o.link_en; endproperty
   a_run_a: assert property (p_run_a) else $error("link off while running a");
   property p_run_b; chan_b_o.dp_clk_en |-> chan_b_o.link_en; endproperty
   a_run_b: assert property (p_run_b) else $error("link off while running b");
endmodule // scp_checker

// ==== testbench/scp_host.sv ====
`timescale 1ns/10ps
module scp_host (
   input wire logic clk_i,
   output scp_pkg::scp_req_t req_o
);
   initial req_o = '0;
   // One request, held over its taking edge
   task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      req_o = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk_i);
      #1;
      req_o = '0;
   endtask
endmodule // scp_host

// ==== testbench/testbench.sv ====
`timescale 1ns/10ps
module testbench;
   logic clk_i;
   logic sys_rst_i = 1'h1;
   scp_pkg::scp_req_t req;
   logic [7:0] rdata;
   logic lsb, asc, prst;
   scp_pkg::scp_chan_ctl_t ca, cb;
   int n_errors = 0;
   int check_count = 0;
   scp_regs scp_regs_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req), .rdata_o(rdata),
      .lsb_first_o(lsb), .addr_ascend_o(asc), .port_rst_o(prst), .chan_a_o(ca), .chan_b_o(cb));
   scp_host scp_host_inst (.clk_i(clk_i), .req_o(req));
   initial begin
      clk_i = 1'h0;
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      if (!(a <= scp_pkg::ADDR_ID_HI || a == scp_pkg::ADDR_CHSEL)) begin
         n_errors++;
         $display("mismatch t=%0t write to unmapped %h", $time, a);
      end
      scp_host_inst.xfer(1'h1, a, d);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      scp_host_inst.xfer(1'h0, a, 8'h00);
      chk(rdata, exp);
   endtask
   task automatic tick;
      @(posedge clk_i);
      #1;
   endtask
   task automatic results;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) tick();
      sys_rst_i = 1'h0;
      rd(16'h0000, 8'h00);
      rd(16'h0008, 8'h03);
      wr(16'h0003, 8'hFF);
      rd(16'h0003, scp_pkg::CLASS_CODE);
      rd(16'h0004, scp_pkg::PART_ID[7:0]);
      rd(16'h0005, scp_pkg::PART_ID[15:8]);
      rd(16'h0009, 8'h00);
      wr(16'h0000, 8'h02);
      rd(16'h0000, 8'h42);
      chk({7'h00, lsb}, 8'h01);
      wr(16'h0000, 8'h20);
      rd(16'h0000, 8'h24);
      chk({6'h00, lsb, asc}, 8'h01);
      wr(16'h0002, 8'h03);
      tick();
      chk({5'h00, ca}, 8'h02);
      chk({5'h00, cb}, 8'h02);
      wr(16'h0008, 8'h01);
      wr(16'h0002, 8'h02);
      tick();
      chk({5'h00, ca}, 8'h01);
      chk({5'h00, cb}, 8'h02);
      wr(16'h0008, 8'h03);
      rd(16'h0002, 8'h02);
      wr(16'h0001, 8'h02);
      tick();
      chk({7'h00, ca.dp_rst}, 8'h01);
      tick();
      chk({7'h00, ca.dp_rst}, 8'h00);
      rd(16'h0001, 8'h00);
      wr(16'h0008, 8'h02);
      wr(16'h0000, 8'h81);
      tick();
      chk({7'h00, prst}, 8'h01);
      repeat (20) tick();
      rd(16'h0002, 8'h00);
      rd(16'h0008, 8'h03);
      chk({5'h00, ca}, 8'h05);
      wr(16'h0000, 8'h24);
      wr(16'h0000, 8'h80);
      tick();
      chk({7'h00, prst}, 8'h01);
      repeat (20) tick();
      rd(16'h0000, 8'h00);
      chk({6'h00, lsb, asc}, 8'h00);
      results();
   end
endmodule // testbench
bind scp_regs scp_checker scp_checker_inst (.clk_i, .sys_rst_i, .req_i, .rdata_o,
   .lsb_first_o, .addr_ascend_o, .port_rst_o, .chan_a_o, .chan_b_o);
